/* File: design/fad_pkg.sv */
// Purpose: constants for the flash address map decoder
// Assumes: 24-bit global byte addresses
// Notes: ranges are inclusive base/last pairs
package fad_pkg;
  localparam int ADDR_W = 24;
  localparam logic [23:0] REG_BASE = 24'h00_0000;
  localparam logic [23:0] REG_LAST = 24'h00_0fff;
  localparam logic [23:0] REG_IMPL_LAST = 24'h00_0017;
  localparam logic [23:0] EE_BASE = 24'h10_0000;
  localparam logic [23:0] EE_LAST = 24'h10_07ff;
  localparam logic [23:0] RES_BASE = 24'h1f_4000;
  localparam logic [23:0] RES_LAST = 24'h1f_ffff;
  localparam logic [23:0] INFO_BASE = 24'h1f_c000;
  localparam logic [23:0] INFO_LAST = 24'h1f_c0ff;
  localparam logic [23:0] VER_BASE = 24'h1f_c0b6;
  localparam logic [23:0] VER_LAST = 24'h1f_c0b7;
  localparam logic [23:0] ONCE_BASE = 24'h1f_c0c0;
  localparam logic [23:0] ONCE_LAST = 24'h1f_c0ff;
  localparam logic [23:0] PF_BASE = 24'hfd_0000;
  localparam logic [23:0] PF_LAST = 24'hff_ffff;
  localparam logic [23:0] PROT_LO_BASE = 24'hff_8000;
  localparam logic [23:0] CFG_BASE = 24'hff_fe00;
  localparam logic [23:0] CFG_LAST = 24'hff_fe0f;
  localparam logic [4:0] CFG_BYTES = 5'h10;
  localparam int BDK_OFS = 'h0;
  localparam int OVK_OFS = 'h8;
  localparam int FPS_OFS = 'hc;
  localparam int EPS_OFS = 'hd;
  localparam int NVO_OFS = 'he;
  localparam int SEC_OFS = 'hf;
  localparam logic [127:0] CFG_RESET = {16{8'hff}};
  typedef enum logic [1:0] {
    FAD_LOAD = 2'b01,
    FAD_READY = 2'b10
  } fad_state_t;
endpackage

/* File: design/fad_dec_if.sv */
// Purpose: carries an address to the region decoder and its answer back
// Assumes: purely combinational decode
// Notes: sizes are in protection units
`timescale 1ns/1ps
interface fad_dec_if;
  logic [23:0] addr;
  logic [7:0] lo_units;
  logic [7:0] hi_units;
  logic reg_hit;
  logic reg_impl;
  logic ee_hit;
  logic res_hit;
  logic info_hit;
  logic ver_hit;
  logic once_hit;
  logic pf_hit;
  logic cfg_hit;
  logic lo_hit;
  logic hi_hit;
  modport src (output addr, lo_units, hi_units, input reg_hit, reg_impl, ee_hit, res_hit,
    info_hit, ver_hit, once_hit, pf_hit, cfg_hit, lo_hit, hi_hit);
  modport dec (input addr, lo_units, hi_units, output reg_hit, reg_impl, ee_hit, res_hit,
    info_hit, ver_hit, once_hit, pf_hit, cfg_hit, lo_hit, hi_hit);
endinterface

/* File: design/fad_region_decode.sv */
// Purpose: classifies a global address into flash module regions
// Assumes: address stable for the cycle
// Notes: protection regions measured in 2**UNIT_LOG2 bytes
`timescale 1ns/1ps
module fad_region_decode #(
  parameter int UNIT_LOG2 = 10
) (
  fad_dec_if.dec d
);
  import fad_pkg::*;
  logic [23:0] lo_end;
  logic [23:0] hi_start;
  always_comb begin
    lo_end = PROT_LO_BASE + 24'(d.lo_units) * (24'h1 << UNIT_LOG2);
    hi_start = PF_LAST - 24'(d.hi_units) * (24'h1 << UNIT_LOG2);
    d.reg_hit = d.addr <= REG_LAST;
    d.reg_impl = d.addr <= REG_IMPL_LAST;
    d.ee_hit = d.addr >= EE_BASE && d.addr <= EE_LAST;
    d.res_hit = d.addr >= RES_BASE && d.addr <= RES_LAST;
    d.info_hit = d.addr >= INFO_BASE && d.addr <= INFO_LAST;
    d.ver_hit = d.addr >= VER_BASE && d.addr <= VER_LAST;
    d.once_hit = d.addr >= ONCE_BASE && d.addr <= ONCE_LAST;
    d.pf_hit = d.addr >= PF_BASE;
    d.cfg_hit = d.addr >= CFG_BASE && d.addr <= CFG_LAST;
    d.lo_hit = d.addr >= PROT_LO_BASE && d.addr < lo_end && d.lo_units != 8'h00;
    d.hi_hit = d.addr > hi_start && d.hi_units != 8'h00;
  end
endmodule // fad_region_decode

/* File: design/fad_top.sv */
// Purpose: flash module address map decode and configuration field load
// Assumes: one access request per cycle, nvm read data in the same cycle as o_nvm_rd
// Notes: all outputs registered; answer one cycle after the request
// Functional notes
// - unimplemented space reads give undefined data
// - writes to unimplemented or reserved space dropped
// - register writes accepted when idle or initialising
// - decode register, eeprom and resource ranges
// - program flash at top of map
// - three activatable program flash protection regions
// - eight byte backdoor key from config field
// - two byte override key from config field
// - four single byte settings from config field
// - two byte version word in information row
// - sixty four byte one-time field
// - information row mapped, rest of area reserved
// - twenty four implemented register bytes
`timescale 1ns/1ps
module fad_top #(
  parameter int UNIT_LOG2 = 10
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [fad_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_command_complete_flag,
  input wire logic [7:0] i_lo_units,
  input wire logic [7:0] i_hi_units,
  input wire logic [2:0] i_prot_act,
  input wire logic [7:0] i_nvm_rdata,
  output logic o_init_busy,
  output logic [fad_pkg::ADDR_W-1:0] o_nvm_addr,
  output logic o_nvm_rd,
  output logic o_sel_reg,
  output logic o_sel_eeprom,
  output logic o_sel_pflash,
  output logic o_sel_info_row,
  output logic o_sel_version,
  output logic o_sel_once,
  output logic o_reg_wr,
  output logic [4:0] o_reg_idx,
  output logic o_wr_ignored,
  output logic o_rd_undef,
  output logic o_prot_hit,
  output logic [63:0] o_backdoor_key,
  output logic [15:0] o_override_key,
  output logic [7:0] o_pflash_protection_setting,
  output logic [7:0] o_eeprom_protection_setting,
  output logic [7:0] o_nonvolatile_option_setting,
  output logic [7:0] o_security_setting
);
  import fad_pkg::*;
  if (UNIT_LOG2 < 0 || UNIT_LOG2 > 15) begin : g_bad_unit
    $error("fad_top: UNIT_LOG2 out of range");
  end

  fad_dec_if dif ();
  assign dif.addr = i_addr;
  assign dif.lo_units = i_lo_units;
  assign dif.hi_units = i_hi_units;
  fad_region_decode #(.UNIT_LOG2(UNIT_LOG2)) u_dec (.d(dif.dec));

  // configuration field load after reset
  fad_state_t st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [3:0] cap_r, cap_nxt;
  logic rd_r, rd_nxt;
  logic [127:0] cfg_r, cfg_nxt;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cap_nxt = cap_r;
    rd_nxt = 1'b0;
    cfg_nxt = cfg_r;
    if (rd_r) begin
      cfg_nxt[8*cap_r +: 8] = i_nvm_rdata;
    end
    case (st_r)
      FAD_LOAD: begin
        if (cnt_r < CFG_BYTES) begin
          rd_nxt = 1'b1;
          cap_nxt = cnt_r[3:0];
          cnt_nxt = cnt_r + 5'h1;
        end else if (!rd_r) begin
          st_nxt = FAD_READY;
        end
      end
      FAD_READY: begin
        st_nxt = FAD_READY;
      end
      default: begin
        st_nxt = FAD_LOAD;
      end
    endcase
  end
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= FAD_LOAD;
      cnt_r <= 5'h0;
      cap_r <= 4'h0;
      rd_r <= 1'b0;
      cfg_r <= CFG_RESET;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
      rd_r <= rd_nxt;
      cfg_r <= cfg_nxt;
    end
  end
  assign o_nvm_rd = rd_r;
  assign o_nvm_addr = CFG_BASE | {20'h0, cap_r};
  assign o_init_busy = (st_r == FAD_LOAD);
  assign o_backdoor_key = cfg_r[8*BDK_OFS +: 64];
  assign o_override_key = cfg_r[8*OVK_OFS +: 16];
  assign o_pflash_protection_setting = cfg_r[8*FPS_OFS +: 8];
  assign o_eeprom_protection_setting = cfg_r[8*EPS_OFS +: 8];
  assign o_nonvolatile_option_setting = cfg_r[8*NVO_OFS +: 8];
  assign o_security_setting = cfg_r[8*SEC_OFS +: 8];

  // access decode and write gating
  logic mapped;
  logic wr_open;
  logic [9:0] acc_nxt, acc_r;
  logic [4:0] idx_nxt;
  logic [4:0] idx_r;
  always_comb begin
    mapped = dif.reg_impl || dif.ee_hit || dif.pf_hit || dif.info_hit;
    wr_open = i_command_complete_flag || st_r == FAD_LOAD;
    idx_nxt = ((i_rd || (i_wr && wr_open)) && dif.reg_impl) ? i_addr[4:0] : idx_r;
    acc_nxt = '0;
    acc_nxt[0] = (i_rd || i_wr) && dif.reg_hit;
    acc_nxt[1] = (i_rd || i_wr) && dif.ee_hit;
    acc_nxt[2] = (i_rd || i_wr) && dif.pf_hit;
    acc_nxt[3] = (i_rd || i_wr) && dif.info_hit;
    acc_nxt[4] = (i_rd || i_wr) && dif.ver_hit;
    acc_nxt[5] = (i_rd || i_wr) && dif.once_hit;
    acc_nxt[6] = i_wr && dif.reg_impl && wr_open;
    acc_nxt[7] = i_wr && (!mapped || (dif.reg_impl && !wr_open));
    acc_nxt[8] = i_rd && !mapped;
    acc_nxt[9] = i_wr && dif.pf_hit && ((i_prot_act[0] && dif.lo_hit) ||
      (i_prot_act[1] && dif.hi_hit) ||
      (i_prot_act[2] && !dif.lo_hit && !dif.hi_hit));
  end
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_r <= '0;
      idx_r <= 5'h0;
    end else begin
      acc_r <= acc_nxt;
      idx_r <= idx_nxt;
    end
  end
  assign o_sel_reg = acc_r[0];
  assign o_sel_eeprom = acc_r[1];
  assign o_sel_pflash = acc_r[2];
  assign o_sel_info_row = acc_r[3];
  assign o_sel_version = acc_r[4];
  assign o_sel_once = acc_r[5];
  assign o_reg_wr = acc_r[6];
  assign o_wr_ignored = acc_r[7];
  assign o_rd_undef = acc_r[8];
  assign o_prot_hit = acc_r[9];
  assign o_reg_idx = idx_r;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_wr_impl_open;
    i_wr && i_addr <= REG_IMPL_LAST && (i_command_complete_flag || o_init_busy);
  endsequence
  sequence s_wr_impl_busy;
    i_wr && i_addr <= REG_IMPL_LAST && !i_command_complete_flag && !o_init_busy;
  endsequence
  a_reg_wr_taken: assert property (s_wr_impl_open |=> o_reg_wr && !o_wr_ignored)
    else $error("open register write not taken");
  a_busy_wr_drop: assert property (s_wr_impl_busy |=> !o_reg_wr && o_wr_ignored)
    else $error("busy register write not dropped");
  a_unimpl_reg_wr: assert property (i_wr && i_addr > REG_IMPL_LAST && i_addr <= REG_LAST
    |=> o_wr_ignored && !o_reg_wr)
    else $error("unimplemented register write taken");
  a_gap_wr_drop: assert property (i_wr && i_addr > REG_LAST && i_addr < EE_BASE
    |=> o_wr_ignored && !o_sel_reg)
    else $error("write to hole not ignored");
  a_rd_undef_flag: assert property (i_rd && !i_wr && i_addr >= RES_BASE && i_addr < INFO_BASE
    |=> o_rd_undef && !o_sel_info_row)
    else $error("reserved read not flagged");
  a_eeprom_sel: assert property (i_rd && i_addr == EE_LAST |=> o_sel_eeprom && !o_rd_undef)
    else $error("eeprom last byte not selected");
  a_pflash_sel: assert property (i_rd && i_addr == PF_BASE |=> o_sel_pflash)
    else $error("pflash base not selected");
  a_version_sel: assert property (i_rd && i_addr == VER_BASE |=>
    o_sel_version && o_sel_info_row)
    else $error("version word not selected");
  a_once_sel: assert property (i_rd && i_addr == ONCE_LAST |=> o_sel_once)
    else $error("one-time field end not selected");
  a_reg_idx_next: assert property (i_rd && i_addr == REG_IMPL_LAST |=> o_reg_idx == 5'h17)
    else $error("register index wrong");
  a_lo_prot_hit: assert property (i_wr && i_prot_act == 3'h1 && i_lo_units != 8'h00 &&
    i_addr == PROT_LO_BASE |=> o_prot_hit)
    else $error("lower protection region missed");
  a_cfg_load_len: assert property ($fell(o_init_busy) |-> $past(o_nvm_addr) == CFG_LAST)
    else $error("config load ended early");
  a_key_capture: assert property (o_nvm_rd && o_nvm_addr == CFG_BASE
    |=> o_backdoor_key[7:0] == $past(i_nvm_rdata))
    else $error("backdoor key byte not captured");
endmodule // fad_top

/* File: sim/fad_nvm_model.sv */
// Purpose: config field storage answering the config loader
// Assumes: byte stands in the same cycle as its read strobe
// Notes: idle data is the inverse of the last byte
`timescale 1ns/1ps
module fad_nvm_model (
  input wire logic i_mclk,
  input wire logic [23:0] i_nvm_addr,
  input wire logic i_nvm_rd,
  output logic [7:0] o_nvm_rdata
);
  logic [7:0] last_r = 8'h00;
  always @(posedge i_mclk) begin
    if (i_nvm_rd) begin
      last_r <= o_nvm_rdata;
    end
  end
  always_comb begin
    if (i_nvm_rd && i_nvm_addr[3:1] == 3'h5) begin
      o_nvm_rdata = 8'hff;
    end else if (i_nvm_rd) begin
      o_nvm_rdata = {4'h5, i_nvm_addr[3:0]};
    end else begin
      o_nvm_rdata = ~last_r;
    end
  end
endmodule // fad_nvm_model

/* File: sim/flash_address_map_decode_tb.sv */
// Purpose: self-checking bench for the flash address map decoder
// Assumes: inputs change on the falling edge
// Notes: answers sampled one falling edge after the request
`timescale 1ns/1ps
module flash_address_map_decode_tb;
  import fad_pkg::*;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic [23:0] i_addr = 24'h00_0000;
  logic i_rd = 1'b0;
  logic i_wr = 1'b0;
  logic i_command_complete_flag = 1'b1;
  logic [7:0] i_lo_units = 8'h01;
  logic [7:0] i_hi_units = 8'h01;
  logic [2:0] i_prot_act = 3'h0;
  logic [7:0] i_nvm_rdata;
  logic [23:0] o_nvm_addr;
  logic [4:0] o_reg_idx;
  logic [63:0] o_backdoor_key;
  logic [15:0] o_override_key;
  logic [7:0] o_fps, o_eps, o_nvo, o_sec;
  logic o_init_busy, o_nvm_rd, o_sel_reg, o_sel_eeprom, o_sel_pflash, o_sel_info_row;
  logic o_sel_version, o_sel_once, o_reg_wr, o_wr_ignored, o_rd_undef, o_prot_hit;
  int n_mismatch = 0;
  int check_count = 0;
  always #25 i_mclk = ~i_mclk;
  fad_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_rd(i_rd),
    .i_wr(i_wr), .i_command_complete_flag(i_command_complete_flag),
    .i_lo_units(i_lo_units), .i_hi_units(i_hi_units), .i_prot_act(i_prot_act),
    .i_nvm_rdata(i_nvm_rdata), .o_init_busy(o_init_busy), .o_nvm_addr(o_nvm_addr),
    .o_nvm_rd(o_nvm_rd), .o_sel_reg(o_sel_reg), .o_sel_eeprom(o_sel_eeprom),
    .o_sel_pflash(o_sel_pflash), .o_sel_info_row(o_sel_info_row),
    .o_sel_version(o_sel_version), .o_sel_once(o_sel_once), .o_reg_wr(o_reg_wr),
    .o_reg_idx(o_reg_idx), .o_wr_ignored(o_wr_ignored), .o_rd_undef(o_rd_undef),
    .o_prot_hit(o_prot_hit), .o_backdoor_key(o_backdoor_key),
    .o_override_key(o_override_key), .o_pflash_protection_setting(o_fps),
    .o_eeprom_protection_setting(o_eps), .o_nonvolatile_option_setting(o_nvo),
    .o_security_setting(o_sec));
  fad_nvm_model nvm (.i_mclk(i_mclk), .i_nvm_addr(o_nvm_addr), .i_nvm_rd(o_nvm_rd),
    .o_nvm_rdata(i_nvm_rdata));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic acc(input logic rd, input logic wr, input logic [23:0] a, input logic f);
    @(negedge i_mclk);
    i_rd = rd;
    i_wr = wr;
    i_addr = a;
    i_command_complete_flag = f;
    @(negedge i_mclk);
    i_rd = 1'b0;
    i_wr = 1'b0;
  endtask
  task automatic t_init();
    int i;
    acc(1'b0, 1'b1, 24'h00_0004, 1'b0);
    chk({o_reg_wr, o_wr_ignored, o_sel_reg}, 3'b101, "init write");
    chk(o_reg_idx, 5'h04, "init index");
    chk({o_nvm_rd, o_nvm_addr}, {1'b1, 24'hfffe01}, "load address");
    for (i = 0; i < 40 && o_init_busy !== 1'b0; i++) begin
      @(negedge i_mclk);
    end
    if (o_init_busy !== 1'b0) begin
      n_mismatch++;
      report_and_stop();
    end
    chk(o_backdoor_key, 64'h5756_5554_5352_5150, "backdoor key");
    chk(o_override_key, 16'h5958, "override key");
    chk({o_fps, o_eps, o_nvo, o_sec}, 32'h5c5d_5e5f, "settings");
  endtask
  // bits: reg eeprom pflash info version once undefined
  localparam logic [30:0] DT [17] = '{{24'h000000, 7'b1000000}, {24'h000017, 7'b1000000},
    {24'h000018, 7'b1000001}, {24'h001000, 7'b0000001}, {24'h100000, 7'b0100000},
    {24'h1007ff, 7'b0100000}, {24'h100800, 7'b0000001}, {24'h1f4000, 7'b0000001},
    {24'h1fc000, 7'b0001000}, {24'h1fc0b6, 7'b0001100}, {24'h1fc0b7, 7'b0001100},
    {24'h1fc0c0, 7'b0001010}, {24'h1fc0ff, 7'b0001010}, {24'h1fc100, 7'b0000001},
    {24'hfcffff, 7'b0000001}, {24'hfd0000, 7'b0010000}, {24'hffffff, 7'b0010000}};
  task automatic t_decode();
    foreach (DT[k]) begin
      acc(1'b1, 1'b0, DT[k][30:7], 1'b1);
      chk({o_sel_reg, o_sel_eeprom, o_sel_pflash, o_sel_info_row, o_sel_version,
        o_sel_once, o_rd_undef}, DT[k][6:0], "read decode");
    end
  endtask
  // address, flag, then register write and ignored
  localparam logic [26:0] WT [8] = '{{24'h000017, 3'b110}, {24'h000018, 3'b101},
    {24'h000004, 3'b001}, {24'h1f4000, 3'b101}, {24'h100000, 3'b100},
    {24'h1fc100, 3'b101}, {24'h123456, 3'b101}, {24'h001000, 3'b101}};
  task automatic t_write();
    foreach (WT[k]) begin
      acc(1'b0, 1'b1, WT[k][26:3], WT[k][2]);
      chk({o_reg_wr, o_wr_ignored}, WT[k][1:0], "write outcome");
    end
    chk(o_reg_idx, 5'h17, "index kept");
  endtask
  // activation, address, protected
  localparam logic [27:0] PT [8] = '{{3'h1, 24'hff8000, 1'b1}, {3'h1, 24'hff83ff, 1'b1},
    {3'h1, 24'hff8400, 1'b0}, {3'h2, 24'hffffff, 1'b1}, {3'h2, 24'hfffc00, 1'b1},
    {3'h2, 24'hfffbff, 1'b0}, {3'h4, 24'hfd0000, 1'b1}, {3'h0, 24'hffffff, 1'b0}};
  task automatic t_prot();
    foreach (PT[k]) begin
      i_prot_act = PT[k][27:25];
      acc(1'b0, 1'b1, PT[k][24:1], 1'b1);
      chk({o_prot_hit, o_sel_pflash}, {PT[k][0], 1'b1}, "protection");
    end
  endtask
  initial begin
    repeat (8) @(negedge i_mclk);
    i_resetn = 1'b1;
    t_init();
    t_decode();
    t_write();
    t_prot();
    report_and_stop();
  end
endmodule // flash_address_map_decode_tb
